// >>> src/ttpa_pkg.sv
// Operation
// RULE1: every selection point grants the two threads in turn whenever both can use the stage.
// RULE2: when one thread cannot use a stage, the other thread gets every cycle of it.
// RULE3: a thread cannot use a stage while it has a cache miss, a branch mispredict or a dependency; the code gates only trace cache fetch this way.
// RULE4: trace cache access is re-arbitrated on every clock cycle.
// RULE5: after a trace line is fetched for one thread, the next fetch goes to the other if both ask.
// RULE6: while one thread waits on second-level fetch returns, the other gets all trace bandwidth.
// RULE7: the micro-op queue is split between the threads whenever both are active.
// RULE8: at most six micro-ops dispatch per cycle, and only those whose operands are ready.
// RULE9: dispatch from the wait queues does not depend on which thread issued the micro-op.
// RULE10: each thread may hold at most half of the reorder buffer entries.
// RULE11: retirement is in program order per thread and alternates while both are ready.
// RULE12: if one thread has nothing ready to retire, the other gets the whole retire bandwidth.
// RULE13: store commit into the data cache alternates between the two threads.
// RULE14: load and store buffers limit each thread to half of their entries.
// RULE15: after reset each alternating point gives first priority to thread zero.
// RULE16: an inactive thread is never granted, and the active one may use whole queues.
package ttpa_pkg;
  localparam int DISPATCH_WIDTH = 6;
  localparam int UOPQ_DEPTH     = 16;
  localparam int ROB_DEPTH      = 128;
  localparam int LDB_DEPTH      = 48;
  localparam int STB_DEPTH      = 24;
  localparam int WAITQ_DEPTH    = 16;
  localparam logic RESET_PRIO   = 1'b0;
endpackage : ttpa_pkg

// >>> src/ttpa_rr_point.sv
`timescale 1ns/100ps
`default_nettype none
// one two-thread alternating selection point
module ttpa_rr_point
  import ttpa_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // requests, already gated by active, and by stall for the fetch point only
  input  wire logic [1:0] req,
  // grant, combinational
  output logic      [1:0] gnt
);
  typedef struct packed {
    logic prio;
  } ttpa_rr_state_type;

  ttpa_rr_state_type st_q;
  ttpa_rr_state_type st_d;

  always_comb begin
    st_d = st_q;
    gnt  = 2'h0;
    if (req == 2'h3) begin
      gnt[st_q.prio] = 1'b1;         // RULE1
    end else begin
      gnt = req;                     // RULE2
    end
    if (gnt[0]) st_d.prio = 1'b1;    // RULE5
    else if (gnt[1]) st_d.prio = 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q.prio <= RESET_PRIO;       // RULE15
    end else begin
      st_q <= st_d;                  // RULE4
    end
  end

  gnt_onehot_a: assert property (@(posedge clk) disable iff (!reset_n)
    gnt != 2'h3) else $error("two grants at once"); // RULE1
  // sampled reset_n keeps out the release edge, where the priority flop is still held
  gnt_alternate_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && req == 2'h3 && gnt[0]) ##1 (req == 2'h3) |-> gnt[1])
    else $error("no alternation"); // RULE5
  gnt_solo_a: assert property (@(posedge clk) disable iff (!reset_n)
    (req == 2'h1 |-> gnt == 2'h1) and (req == 2'h2 |-> gnt == 2'h2))
    else $error("lone requester not granted"); // RULE2
  gnt_noreq_a: assert property (@(posedge clk) disable iff (!reset_n)
    (gnt & ~req) == 2'h0) else $error("grant without request"); // RULE16
  cov_both_c: cover property (@(posedge clk) disable iff (!reset_n)
    req == 2'h3 ##1 req == 2'h3);
  cov_solo_c: cover property (@(posedge clk) disable iff (!reset_n) req == 2'h2);
endmodule : ttpa_rr_point
`default_nettype wire

// >>> src/ttpa_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
// two-thread sharing logic for the shared pipeline selection points
module ttpa_arbiter
  import ttpa_pkg::*;
#(
  parameter int DISPATCH_W = DISPATCH_WIDTH,
  parameter int WAITQ_N    = WAITQ_DEPTH,
  parameter int UOPQ_N     = UOPQ_DEPTH,
  parameter int ROB_N      = ROB_DEPTH,
  parameter int LDB_N      = LDB_DEPTH,
  parameter int STB_N      = STB_DEPTH
)
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // thread state
  input  wire logic [1:0]         thr_active,
  input  wire logic [1:0]         thr_cache_miss,
  input  wire logic [1:0]         thr_mispredict,
  input  wire logic [1:0]         thr_dep_stall,
  input  wire logic [1:0]         thr_l2_wait,
  // trace cache fetch
  input  wire logic [1:0]         fetch_req,
  output logic      [1:0]         fetch_gnt,
  // micro-op queue, rename side
  input  wire logic [1:0]         uopq_push,
  input  wire logic [1:0]         uopq_pop,
  output logic      [1:0]         uopq_room,
  // wait queue, one ready bit per entry
  input  wire logic [WAITQ_N-1:0] wq_ready,
  output logic      [WAITQ_N-1:0] wq_dispatch,
  // reorder buffer
  input  wire logic [1:0]         rob_alloc,
  input  wire logic [1:0]         rob_free,
  output logic      [1:0]         rob_room,
  // retirement
  input  wire logic [1:0]         retire_ready,
  output logic      [1:0]         retire_gnt,
  // load and store buffers
  input  wire logic [1:0]         ldb_alloc,
  input  wire logic [1:0]         ldb_free,
  output logic      [1:0]         ldb_room,
  input  wire logic [1:0]         stb_alloc,
  input  wire logic [1:0]         stb_free,
  output logic      [1:0]         stb_room,
  // store commit to data cache
  input  wire logic [1:0]         commit_req,
  output logic      [1:0]         commit_gnt
);
  if (DISPATCH_W < 1 || DISPATCH_W > WAITQ_N || WAITQ_N > 64) begin : g_bad_dispatch
    $error("bad dispatch or wait queue size");
  end
  // occupancy counters are eight bits wide
  if (UOPQ_N < 2 || ROB_N < 2 || LDB_N < 2 || STB_N < 2 ||
      UOPQ_N > 255 || ROB_N > 255 || LDB_N > 255 || STB_N > 255) begin : g_bad_depth
    $error("partitioned buffers need two to 255 entries");
  end

  localparam int CW = 8;
  localparam int NB = 5;

  typedef struct packed {
    logic [1:0]         fetch_gnt;
    logic [1:0]         retire_gnt;
    logic [1:0]         commit_gnt;
    logic [WAITQ_N-1:0] wq_dispatch;
    logic [1:0]         room_uopq;
    logic [1:0]         room_rob;
    logic [1:0]         room_ldb;
    logic [1:0]         room_stb;
  } ttpa_out_type;

  typedef struct packed {
    logic [NB-1:0][1:0][CW-1:0] cnt;
    ttpa_out_type               o;
  } ttpa_state_type;

  ttpa_state_type st_q;
  ttpa_state_type st_d;

  logic [1:0] blocked;
  logic [1:0] f_req;
  logic [1:0] r_req;
  logic [1:0] c_req;
  logic [1:0] f_gnt;
  logic [1:0] r_gnt;
  logic [1:0] c_gnt;
  logic [NB-1:0][1:0] inc;
  logic [NB-1:0][1:0] dec;
  logic [NB-1:0][CW-1:0] cap;

  assign blocked = thr_cache_miss | thr_mispredict | thr_dep_stall | thr_l2_wait; // RULE3
  assign f_req   = fetch_req & thr_active & ~blocked;   // RULE6
  assign r_req   = retire_ready & thr_active;           // RULE12
  assign c_req   = commit_req & thr_active;             // RULE16

  ttpa_rr_point u_fetch  (.clk(clk), .reset_n(reset_n), .req(f_req), .gnt(f_gnt)); // RULE4
  ttpa_rr_point u_retire (.clk(clk), .reset_n(reset_n), .req(r_req), .gnt(r_gnt)); // RULE11
  ttpa_rr_point u_commit (.clk(clk), .reset_n(reset_n), .req(c_req), .gnt(c_gnt)); // RULE13

  assign inc = {stb_alloc, ldb_alloc, rob_alloc, uopq_push, 2'h0};
  assign dec = {stb_free, ldb_free, rob_free, uopq_pop, 2'h0};
  assign cap = {CW'(STB_N), CW'(LDB_N), CW'(ROB_N), CW'(UOPQ_N), CW'(0)};

  function automatic logic [1:0] room_of(input logic [1:0][CW-1:0] c,
                                         input logic [CW-1:0] size,
                                         input logic [1:0] act);
    logic [1:0] r;
    r = 2'h0;
    for (int t = 0; t < 2; t++) begin
      if (act == 2'h3) r[t] = c[t] < (size >> 1);         // RULE7 RULE10 RULE14
      else r[t] = act[t] && ((c[0] + c[1]) < size);       // RULE16
    end
    return r;
  endfunction

  always_comb begin
    int n;
    n = 0;
    st_d = st_q;
    for (int b = 1; b < NB; b++) begin
      for (int t = 0; t < 2; t++) begin
        st_d.cnt[b][t] = st_q.cnt[b][t] + CW'(inc[b][t]) - CW'(dec[b][t]);
      end
    end
    st_d.cnt[0] = '0;
    st_d.o.fetch_gnt  = f_gnt;
    st_d.o.retire_gnt = r_gnt;
    st_d.o.commit_gnt = c_gnt;
    st_d.o.room_uopq  = room_of(st_d.cnt[1], cap[1], thr_active);
    st_d.o.room_rob   = room_of(st_d.cnt[2], cap[2], thr_active);
    st_d.o.room_ldb   = room_of(st_d.cnt[3], cap[3], thr_active);
    st_d.o.room_stb   = room_of(st_d.cnt[4], cap[4], thr_active);
    // oldest-first by slot, thread-blind
    for (int i = 0; i < WAITQ_N; i++) begin
      st_d.o.wq_dispatch[i] = 1'b0;
      if (wq_ready[i] && n < DISPATCH_W) begin               // RULE8 RULE9
        st_d.o.wq_dispatch[i] = 1'b1;
        n = n + 1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign fetch_gnt   = st_q.o.fetch_gnt;
  assign retire_gnt  = st_q.o.retire_gnt;
  assign commit_gnt  = st_q.o.commit_gnt;
  assign wq_dispatch = st_q.o.wq_dispatch;
  assign uopq_room   = st_q.o.room_uopq;
  assign rob_room    = st_q.o.room_rob;
  assign ldb_room    = st_q.o.room_ldb;
  assign stb_room    = st_q.o.room_stb;

  dispatch_max_a: assert property (@(posedge clk) disable iff (!reset_n)
    $countones(wq_dispatch) <= DISPATCH_W) else $error("too many dispatched"); // RULE8
  dispatch_ready_a: assert property (@(posedge clk) disable iff (!reset_n)
    ##1 ((wq_dispatch & ~$past(wq_ready)) == '0)) else $error("dispatch not ready"); // RULE8
  fetch_block_a: assert property (@(posedge clk) disable iff (!reset_n)
    blocked[0] |=> !fetch_gnt[0]) else $error("blocked thread fetched"); // RULE3
  fetch_full_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && thr_l2_wait[1] && f_req[0]) |=> fetch_gnt == 2'h1)
    else $error("bandwidth lost"); // RULE6
  retire_solo_a: assert property (@(posedge clk) disable iff (!reset_n)
    (reset_n && r_req == 2'h2) |=> retire_gnt == 2'h2) else $error("retire slot idle"); // RULE12
  inactive_nogrant_a: assert property (@(posedge clk) disable iff (!reset_n)
    !thr_active[1] |=> !fetch_gnt[1] && !retire_gnt[1] && !commit_gnt[1])
    else $error("inactive thread granted"); // RULE16
  rob_half_a: assert property (@(posedge clk) disable iff (!reset_n)
    ($past(thr_active) == 2'h3 && st_q.cnt[2][0] >= CW'(ROB_N / 2)) |-> !rob_room[0])
    else $error("rob past half"); // RULE10
  first_prio_a: assert property (@(posedge clk)
    $rose(reset_n) && f_req == 2'h3 |=> fetch_gnt == 2'h1)
    else $error("thread zero not first after reset"); // RULE15
  cov_alt_c: cover property (@(posedge clk) disable iff (!reset_n)
    fetch_gnt == 2'h1 ##1 fetch_gnt == 2'h2 ##1 fetch_gnt == 2'h1);
  cov_full_c: cover property (@(posedge clk) disable iff (!reset_n)
    $countones(wq_dispatch) == DISPATCH_W);
  cov_commit_c: cover property (@(posedge clk) disable iff (!reset_n)
    commit_gnt == 2'h2 ##1 commit_gnt == 2'h1);
endmodule : ttpa_arbiter
`default_nettype wire

// >>> dv/ttpa_far_model.sv
`timescale 1ns/100ps
`default_nettype none
// queue requester: one alloc then a gap, so room always reflects it
module ttpa_far_model
  import ttpa_pkg::*;
#(parameter int SEED = 1)
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // room and drain mode
  input  wire logic [1:0] room,
  input  wire logic       drain,
  // pulses
  output logic      [1:0] alloc,
  output logic      [1:0] free
);
  logic [7:0]  cnt [2];
  logic [15:0] lf;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      alloc <= 2'h0;
      free  <= 2'h0;
      cnt   <= '{default: 8'h0};
      lf    <= 16'(SEED);
    end else begin
      lf <= {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      for (int t = 0; t < 2; t++) begin
        alloc[t] <= room[t] & !alloc[t] & !drain & lf[t];
        free[t]  <= (cnt[t] > 8'h1) & !free[t] & (drain | (lf[t+2] & lf[t+4]));
        cnt[t]   <= cnt[t] + {7'h0, alloc[t]} - {7'h0, free[t]};
      end
    end
  end
endmodule : ttpa_far_model
`default_nettype wire

// >>> dv/test_ttpa_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
module test_ttpa_arbiter;
  import ttpa_pkg::*;
  localparam int LIM [4] = '{16, 16, 12, 8};
  logic        clk, reset_n, drain, pr [3];
  logic [1:0]  act, cm, mp, dp, l2, freq, rreq, creq, fg, rg, cg;
  logic [1:0]  al [4], fr [4], rm [4], rq [3], e_g [3], e_rm [4];
  logic [15:0] wq, wd, e_wd;
  logic [7:0]  cnt [4][2];
  logic [31:0] seed = 32'h37;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  ttpa_arbiter #(.ROB_N(16), .LDB_N(12), .STB_N(8)) dut (.clk(clk), .reset_n(reset_n),
    .thr_active(act), .thr_cache_miss(cm), .thr_mispredict(mp), .thr_dep_stall(dp),
    .thr_l2_wait(l2), .fetch_req(freq), .fetch_gnt(fg), .uopq_push(al[0]), .uopq_pop(fr[0]),
    .uopq_room(rm[0]), .wq_ready(wq), .wq_dispatch(wd), .rob_alloc(al[1]), .rob_free(fr[1]),
    .rob_room(rm[1]), .retire_ready(rreq), .retire_gnt(rg), .ldb_alloc(al[2]),
    .ldb_free(fr[2]), .ldb_room(rm[2]), .stb_alloc(al[3]), .stb_free(fr[3]),
    .stb_room(rm[3]), .commit_req(creq), .commit_gnt(cg));
  for (genvar k = 0; k < 4; k++) begin : g_far
    ttpa_far_model #(.SEED(k + 3)) far (.clk(clk), .reset_n(reset_n), .room(rm[k]),
      .drain(drain), .alloc(al[k]), .free(fr[k]));
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [1:0] arb(input logic [1:0] r, input logic p);
    if (r == 2'h3) return p ? 2'h2 : 2'h1;
    return r;
  endfunction : arb
  function automatic logic [15:0] low6(input logic [15:0] r);
    logic [15:0] o;
    int          n;
    o = 16'h0;
    n = 0;
    for (int i = 0; i < 16; i++) if (r[i] && n < 6) begin
      o[i] = 1'b1;
      n++;
    end
    return o;
  endfunction : low6
  task automatic cmp2(input logic [1:0] got, input logic [1:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp2
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp16
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // expected outputs from the values the design samples at this edge
  always @(posedge clk) begin
    rq[0] = freq & act & ~(cm | mp | dp | l2);
    rq[1] = rreq & act;
    rq[2] = creq & act;
    for (int k = 0; k < 3; k++) begin
      e_g[k] = reset_n ? arb(rq[k], pr[k]) : 2'h0;
      pr[k] = reset_n & ((e_g[k] == 2'h0) ? pr[k] : e_g[k][0]);
    end
    e_wd = reset_n ? low6(wq) : 16'h0;
    for (int k = 0; k < 4; k++) for (int t = 0; t < 2; t++) begin
      cnt[k][t] = reset_n ? cnt[k][t] + {7'h0, al[k][t]} - {7'h0, fr[k][t]} : 8'h0;
      e_rm[k][t] = reset_n && act[t] && (cnt[k][t] < 8'((act == 2'h3) ? LIM[k] / 2 : LIM[k]));
    end
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      complete_run();
    end
  end
  always @(negedge clk) if (reset_n) begin
    cmp2(fg, e_g[0]);
    cmp2(rg, e_g[1]);
    cmp2(cg, e_g[2]);
    cmp16(wd, e_wd);
    cmp2(rm[0], e_rm[0]);
    cmp2(rm[1], e_rm[1]);
    cmp2(rm[2], e_rm[2]);
    cmp2(rm[3], e_rm[3]);
  end else cmp2(fg | rg | cg, 2'h0);
  task automatic run(input int n, input logic d);
    logic [31:0] r;
    drain <= d;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      r = xs();
      freq <= r[1:0] | r[3:2];
      rreq <= r[5:4] | r[7:6];
      creq <= r[9:8] | r[25:24];
      cm   <= r[11:10] & r[13:12] & r[15:14];
      mp   <= r[13:12] & r[17:16] & r[19:18];
      dp   <= r[19:18] & r[21:20] & r[23:22];
      l2   <= r[27:26] & r[29:28] & r[31:30];
      wq   <= (i % 50 == 0) ? 16'hffff : r[31:16] ^ r[15:0];
    end
  endtask : run
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {reset_n, drain, act, cm, mp, dp, l2, freq, rreq, creq, wq} <= '0;
    foreach (LIM[p]) if (p < 3) begin
      act <= (p == 0) ? 2'h3 : 2'(p);
      // corner: both threads already asking when reset lets go
      {cm, mp, dp, l2} <= 8'h0;
      {freq, rreq, creq} <= 6'h3f;
      reset_n <= 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      run(300, 1'b0);
      run(200, 1'b1);
    end
    complete_run();
  end
endmodule : test_ttpa_arbiter
`default_nettype wire
